// File: rtl/alp_device.sv
// Converter-side power mode controller.
// Assumes link inputs are synchronous to clk_in.
`include "alp_defs.svh"
module alp_device
  import alp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Link
  alp_link_if.device link,
  // Core status
  output logic analog_powered_out,
  output logic low_power_acq_out,
  output logic conv_busy_out,
  output logic [7:0] pwrctl_out
);
  alp_dev_state_e state_reg;
  logic pin_d_reg;
  logic unlocked_reg;
  logic [7:0] reset_power_control_register;
  logic [7:0] conv_cnt_reg;
  logic ready_reg;
  logic rise;
  logic fall;
  logic light_sleep_enable_bit;
  logic deep_sleep_request_bit;

  assign rise = link.conversion_start_select_pin & ~pin_d_reg;
  assign fall = ~link.conversion_start_select_pin & pin_d_reg;
  assign light_sleep_enable_bit = reset_power_control_register[`ALP_LIGHT_SLEEP_BIT];
  assign deep_sleep_request_bit = reset_power_control_register[`ALP_DEEP_SLEEP_BIT];
  assign link.ready_indicator_pin = ready_reg;

  // ==========================================================
  // Pin edge history
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_d_reg <= 1'b0;
    end else begin
      pin_d_reg <= link.conversion_start_select_pin;
    end
  end

  // ==========================================================
  // Key unlock and control register
  // Unlock lasts until the next control write or a wrong key write, so each change needs a fresh key.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      unlocked_reg <= 1'b0;
      reset_power_control_register <= `ALP_PWRCTL_RESET;
    end else if (link.wr_valid) begin
      if (link.wr_addr == `ALP_UNLOCK_ADDR) begin
        unlocked_reg <= (link.wr_data == `ALP_UNLOCK_KEY);
      end else if (link.wr_addr == `ALP_PWRCTL_ADDR) begin
        unlocked_reg <= 1'b0;
        if (unlocked_reg) begin
          reset_power_control_register <= link.wr_data;
        end
      end
    end
  end

  // ==========================================================
  // Power state machine
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ALP_DEV_IDLE;
      conv_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        ALP_DEV_IDLE: begin
          if (rise && deep_sleep_request_bit) begin
            state_reg <= ALP_DEV_DEEP;
          end else if (rise) begin
            state_reg <= ALP_DEV_CONV;
            conv_cnt_reg <= 8'(`ALP_CONV_CYCLES - 1);
          end
        end
        ALP_DEV_CONV: begin
          if (conv_cnt_reg != 8'h00) begin
            conv_cnt_reg <= conv_cnt_reg - 8'h01;
          end else if (light_sleep_enable_bit && link.conversion_start_select_pin) begin
            state_reg <= ALP_DEV_LIGHT;
          end else begin
            state_reg <= ALP_DEV_IDLE;
          end
        end
        ALP_DEV_LIGHT: begin
          if (fall) begin
            state_reg <= ALP_DEV_IDLE;
          end
        end
        ALP_DEV_DEEP: begin
          if (!deep_sleep_request_bit) begin
            state_reg <= ALP_DEV_WAKE;
            conv_cnt_reg <= 8'(`ALP_DS_WAKE_CYCLES - 1);
          end
        end
        ALP_DEV_WAKE: begin
          if (conv_cnt_reg != 8'h00) begin
            conv_cnt_reg <= conv_cnt_reg - 8'h01;
          end else begin
            state_reg <= ALP_DEV_IDLE;
          end
        end
        default: begin
          state_reg <= ALP_DEV_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs, all registered
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ready_reg <= 1'b1;
      analog_powered_out <= 1'b1;
      low_power_acq_out <= 1'b0;
      conv_busy_out <= 1'b0;
      pwrctl_out <= `ALP_PWRCTL_RESET;
    end else begin
      ready_reg <= (state_reg != ALP_DEV_CONV);
      analog_powered_out <= (state_reg != ALP_DEV_DEEP);
      low_power_acq_out <= (state_reg == ALP_DEV_LIGHT);
      conv_busy_out <= (state_reg == ALP_DEV_CONV);
      pwrctl_out <= reset_power_control_register;
    end
  end
endmodule // alp_device

// File: rtl/alp_defs.svh
// Constants for the converter low-power mode control link.
// Assumes one 250 MHz clock shared by both ends.
`ifndef ALP_DEFS_SVH
`define ALP_DEFS_SVH

`define ALP_UNLOCK_ADDR 8'h05
`define ALP_UNLOCK_KEY 8'h69
`define ALP_PWRCTL_ADDR 8'h04
`define ALP_LIGHT_SLEEP_BIT 0
`define ALP_DEEP_SLEEP_BIT 1
`define ALP_PWRCTL_RESET 8'h00
`define ALP_CLK_NS 4
`define ALP_CONV_NS 40
`define ALP_CONV_CYCLES ((`ALP_CONV_NS + `ALP_CLK_NS - 1) / `ALP_CLK_NS)
`define ALP_LS_WAKE_NS 100
`define ALP_LS_WAKE_CYCLES ((`ALP_LS_WAKE_NS + `ALP_CLK_NS - 1) / `ALP_CLK_NS)
`define ALP_DS_WAKE_NS 400
`define ALP_DS_WAKE_CYCLES ((`ALP_DS_WAKE_NS + `ALP_CLK_NS - 1) / `ALP_CLK_NS)

`endif

// File: rtl/alp_pkg.sv
// Types shared by both ends of the low-power mode control link.
// Assumes alp_defs.svh provides the numeric constants.
package alp_pkg;
  typedef enum logic [2:0] {
    ALP_DEV_IDLE, ALP_DEV_CONV, ALP_DEV_LIGHT, ALP_DEV_DEEP, ALP_DEV_WAKE
  } alp_dev_state_e;
  typedef enum logic [2:0] {
    ALP_HOST_IDLE, ALP_HOST_UNLOCK, ALP_HOST_WRITE, ALP_HOST_CONV, ALP_HOST_WAIT
  } alp_host_state_e;
endpackage

// File: rtl/alp_link_if.sv
// Link between host and converter: start pin, register write port, ready pin.
// Assumes both ends run on the same clock.
interface alp_link_if;
  logic conversion_start_select_pin;
  logic wr_valid;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic ready_indicator_pin;
  modport device (input conversion_start_select_pin, input wr_valid, input wr_addr,
    input wr_data, output ready_indicator_pin);
  modport host (output conversion_start_select_pin, output wr_valid, output wr_addr,
    output wr_data, input ready_indicator_pin);
endinterface

// File: rtl/alp_host.sv
// Host-side controller: unlocks and writes power control, paces conversions.
// Assumes a single-cycle command pulse from user logic.
`include "alp_defs.svh"
module alp_host
  import alp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Link
  alp_link_if.host link,
  // User commands
  input wire logic cfg_req_in,
  input wire logic [7:0] cfg_data_in,
  input wire logic conv_req_in,
  input wire logic hold_high_in,
  // User status
  output logic busy_out,
  output logic done_out
);
  alp_host_state_e state_reg;
  logic [7:0] cnt_reg;
  logic [7:0] data_reg;
  logic pin_reg;
  logic wr_valid_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic deep_cleared;

  assign link.conversion_start_select_pin = pin_reg;
  assign link.wr_valid = wr_valid_reg;
  assign link.wr_addr = wr_addr_reg;
  assign link.wr_data = wr_data_reg;
  assign deep_cleared = data_reg[`ALP_DEEP_SLEEP_BIT] == 1'b0;

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ALP_HOST_IDLE;
      cnt_reg <= 8'h00;
      data_reg <= `ALP_PWRCTL_RESET;
      pin_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      wr_valid_reg <= 1'b0;
      done_out <= 1'b0;
      case (state_reg)
        ALP_HOST_IDLE: begin
          if (cfg_req_in) begin
            data_reg <= cfg_data_in;
            wr_valid_reg <= 1'b1;
            wr_addr_reg <= `ALP_UNLOCK_ADDR;
            wr_data_reg <= `ALP_UNLOCK_KEY;
            state_reg <= ALP_HOST_UNLOCK;
            busy_out <= 1'b1;
          end else if (conv_req_in) begin
            pin_reg <= 1'b1;
            cnt_reg <= 8'(`ALP_CONV_CYCLES + 1);
            state_reg <= ALP_HOST_CONV;
            busy_out <= 1'b1;
          end
        end
        ALP_HOST_UNLOCK: begin
          wr_valid_reg <= 1'b1;
          wr_addr_reg <= `ALP_PWRCTL_ADDR;
          wr_data_reg <= data_reg;
          state_reg <= ALP_HOST_WRITE;
        end
        ALP_HOST_WRITE: begin
          // Written value clears the deep sleep bit: wait out deep wake, else nothing to wait for
          cnt_reg <= deep_cleared ? 8'(`ALP_DS_WAKE_CYCLES + 1) : 8'h00;
          state_reg <= ALP_HOST_WAIT;
        end
        ALP_HOST_CONV: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (!hold_high_in) begin
            pin_reg <= 1'b0;
            cnt_reg <= 8'(`ALP_LS_WAKE_CYCLES);
            state_reg <= ALP_HOST_WAIT;
          end
        end
        ALP_HOST_WAIT: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            state_reg <= ALP_HOST_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        default: begin
          state_reg <= ALP_HOST_IDLE;
        end
      endcase
    end
  end
endmodule // alp_host

// File: sim/alp_link_chk.sv
// Concurrent checks on the host-converter link signals.
// Assumes tb instantiates it beside the link interface.
`include "alp_defs.svh"
module alp_link_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Link signals
  input wire logic conversion_start_select_pin,
  input wire logic wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic ready_indicator_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================
  // Helper state
  logic [7:0] low_cnt_reg;
  logic [7:0] cfg_cnt_reg;
  logic deep_arm_reg;
  wire pin = conversion_start_select_pin;
  wire rdy = ready_indicator_pin;
  wire cfg_wr = wr_valid && wr_addr == `ALP_PWRCTL_ADDR;
  // Saturating gaps start high so the first start is legal
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) low_cnt_reg <= 8'hFF;
    else if (pin) low_cnt_reg <= 8'h00;
    else if (low_cnt_reg != 8'hFF) low_cnt_reg <= low_cnt_reg + 8'h01;
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) cfg_cnt_reg <= 8'hFF;
    else if (cfg_wr && !wr_data[1]) cfg_cnt_reg <= 8'h00;
    else if (cfg_cnt_reg != 8'hFF) cfg_cnt_reg <= cfg_cnt_reg + 8'h01;
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) deep_arm_reg <= 1'b0;
    else if (cfg_wr) deep_arm_reg <= wr_data[1];
  end
  // ==========================================
  // Assertions
  sequence unlock_s;
    wr_valid && wr_addr == `ALP_UNLOCK_ADDR && wr_data == `ALP_UNLOCK_KEY;
  endsequence
  sequence start_s;
    $rose(pin);
  endsequence
  unlock_pair_a: assert property (unlock_s |=> cfg_wr)
    else $error("key not followed by control write");
  write_key_a: assert property (cfg_wr |-> $past(wr_valid)
      && $past(wr_addr) == `ALP_UNLOCK_ADDR && $past(wr_data) == `ALP_UNLOCK_KEY)
    else $error("control write without key");
  pin_hold_a: assert property (start_s |-> pin [*8])
    else $error("start pin dropped early");
  // Registered ready lags the state by one cycle: low for ten samples
  conv_ready_a: assert property ($fell(rdy) |-> ##9 !rdy ##1 rdy)
    else $error("ready low span wrong");
  ls_gap_a: assert property (start_s |-> low_cnt_reg >= 8'(`ALP_LS_WAKE_CYCLES))
    else $error("start before light wake time");
  ds_gap_a: assert property (start_s |-> cfg_cnt_reg >= 8'(`ALP_DS_WAKE_CYCLES))
    else $error("start before deep wake time");
  deep_ready_a: assert property ($rose(pin) && deep_arm_reg |-> rdy [*8])
    else $error("ready low in deep sleep");
  wake_ready_a: assert property (cfg_wr && !wr_data[1] |=> rdy [*8])
    else $error("ready low during power up");
endmodule // alp_link_chk

// File: sim/tb.sv
// Self-checking bench: both link ends joined, user sides driven.
// Assumes the rtl files and alp_defs.svh are on the include path.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cfg_req_in = 1'b0;
  logic conv_req_in = 1'b0;
  logic hold_high_in = 1'b0;
  logic [7:0] cfg_data_in = 8'h00;
  logic [7:0] cur_cfg = 8'h00;
  logic busy_out, done_out, analog_powered_out, low_power_acq_out, conv_busy_out;
  logic [7:0] pwrctl_out;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int compares = 0;
  int seed = 44;
  int n;
  alp_link_if link();
  alp_device alp_device_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link),
    .analog_powered_out(analog_powered_out), .low_power_acq_out(low_power_acq_out),
    .conv_busy_out(conv_busy_out), .pwrctl_out(pwrctl_out));
  alp_host alp_host_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(link),
    .cfg_req_in(cfg_req_in), .cfg_data_in(cfg_data_in), .conv_req_in(conv_req_in),
    .hold_high_in(hold_high_in), .busy_out(busy_out), .done_out(done_out));
  alp_link_chk alp_link_chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .conversion_start_select_pin(link.conversion_start_select_pin),
    .wr_valid(link.wr_valid), .wr_addr(link.wr_addr), .wr_data(link.wr_data),
    .ready_indicator_pin(link.ready_indicator_pin));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // ==========================================
  // Tasks
  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_done();
    for (n = 0; n < 400 && done_out !== 1'b1; n++) @(posedge clk_in);
    check(done_out === 1'b1, "no done pulse");
    @(posedge clk_in);
  endtask
  task automatic cfg(input logic [7:0] d);
    @(posedge clk_in);
    cfg_data_in <= d;
    cfg_req_in <= 1'b1;
    cur_cfg = d;
    exp_q.push_back(d);
    @(posedge clk_in);
    cfg_req_in <= 1'b0;
    wait_done();
  endtask
  // Held start skips the done wait: host parks in ALP_HOST_CONV with the start pin high
  task automatic conv(input logic hold);
    @(posedge clk_in);
    hold_high_in <= hold;
    conv_req_in <= 1'b1;
    exp_q.push_back(cur_cfg);
    @(posedge clk_in);
    conv_req_in <= 1'b0;
    if (!hold) wait_done();
  endtask
  // ==========================================
  // Result monitor
  always @(posedge clk_in) begin
    if (done_out === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected done");
      else check(pwrctl_out === exp_q.pop_front(), "control copy");
    end
  end
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    check(pwrctl_out === 8'h00, "control not reset");
    check(link.ready_indicator_pin === 1'b1, "ready low in reset");
    check(analog_powered_out === 1'b1, "analog off in reset");
    reset_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg({7'h00, 1'($random(seed))});
      conv(1'b0);
      check(analog_powered_out === 1'b1, "powered down between");
      check(busy_out === 1'b0, "host still busy");
      check(conv_busy_out === 1'b0, "conversion still busy");
    end
    $display("test random_cfg done");
    cfg(8'h01);
    conv(1'b1);
    repeat (3) @(posedge clk_in);
    check(conv_busy_out === 1'b1, "not converting");
    check(busy_out === 1'b1, "host not busy");
    check(link.ready_indicator_pin === 1'b0, "ready high while converting");
    for (n = 0; n < 60 && low_power_acq_out !== 1'b1; n++) @(posedge clk_in);
    check(low_power_acq_out === 1'b1, "no light sleep");
    hold_high_in <= 1'b0;
    for (n = 0; n < 60 && low_power_acq_out !== 1'b0; n++) @(posedge clk_in);
    check(low_power_acq_out === 1'b0, "no light wake");
    wait_done();
    $display("test light_sleep done");
    cfg(8'h02);
    check(analog_powered_out === 1'b1, "deep sleep before start edge");
    conv(1'b0);
    check(analog_powered_out === 1'b0, "analog on in deep");
    check(link.ready_indicator_pin === 1'b1, "ready low in deep");
    cfg(8'h00);
    for (n = 0; n < 200 && analog_powered_out !== 1'b1; n++) @(posedge clk_in);
    check(analog_powered_out === 1'b1, "no power up");
    conv(1'b0);
    $display("test deep_sleep done");
    finish_test();
  end
endmodule // tb
